// ===== t1_err_pkg.sv
// Purpose: shared constants for the receive error counter block
// Assumes: 100 MHz mclk, registers reached over classic Wishbone
// Notes: register indices are word indices, byte address is index * 4
package t1_err_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned ONE_SECOND_NS = 1_000_000_000;
    localparam int unsigned SECOND_CYCLES = ONE_SECOND_NS / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // counter widths
    localparam int unsigned LCV_WIDTH = 16;
    localparam int unsigned PATH_WIDTH = 12;
    localparam int unsigned OOS_WIDTH = 12;

    ////////////////////////////////////////////////////////////////////////
    // bus
    localparam int unsigned ADR_WIDTH = 10;
    localparam int unsigned DAT_WIDTH = 32;
    localparam int unsigned SEL_WIDTH = 4;

    ////////////////////////////////////////////////////////////////////////
    // register indices
    localparam logic [7:0] IDX_LCV_HI = 8'h23;
    localparam logic [7:0] IDX_LCV_LO = 8'h24;
    localparam logic [7:0] IDX_HIGH_NIBBLES = 8'h25;
    localparam logic [7:0] IDX_PATH_LO = 8'h26;
    localparam logic [7:0] IDX_OOS_LO = 8'h27;
    localparam logic [7:0] IDX_CTRL = 8'h30;
    localparam logic [7:0] IDX_STATUS = 8'h31;
    localparam logic [7:0] IDX_MASK = 8'h32;

    ////////////////////////////////////////////////////////////////////////
    // control fields
    localparam int unsigned CTRL_EXCESS_ZERO = 0;
    localparam int unsigned CTRL_ZERO_SUB = 1;
    localparam int unsigned CTRL_FRAMING_ESF = 2;
    localparam int unsigned CTRL_COUNT_FS = 3;
    localparam int unsigned CTRL_OOS_SEL = 4;
    localparam int unsigned CTRL_WIDTH = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    ////////////////////////////////////////////////////////////////////////
    // status and mask fields
    localparam int unsigned STAT_SECOND = 0;
    localparam int unsigned STAT_SATURATED = 1;
    localparam int unsigned STAT_WIDTH = 2;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

endpackage

// ===== sat_err_counter.sv
// Purpose: saturating running counter with a held copy for the host
// Assumes: inc is the number of events in this cycle, at most 2
// Notes: latch moves the running total into the held copy
`timescale 1ns/10ps
module sat_err_counter #(
    parameter int unsigned W = t1_err_pkg::PATH_WIDTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // events
    input wire logic [1:0] inc,
    input wire logic latch,
    // counts
    output logic [W-1:0] run_q,
    output logic [W-1:0] held_q,
    output logic full
);
    import t1_err_pkg::*;

    localparam logic [W-1:0] MAX = '1;

    function automatic logic [W-1:0] sat_add(input logic [W-1:0] a,
                                             input logic [1:0] b);
        logic [W:0] s;
        s = {1'b0, a} + {{(W-1){1'b0}}, b};
        return s[W] ? MAX : s[W-1:0];
    endfunction

    // restart on the transfer edge, this cycle's events go with it
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            run_q <= '0;
        end else if (latch) begin
            run_q <= '0;
        end else begin
            run_q <= sat_add(run_q, inc);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            held_q <= '0;
        end else if (latch) begin
            held_q <= sat_add(run_q, inc);
        end
    end

    assign full = (run_q == MAX);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_sat_no_wrap: assert property (
        full && !latch |=> full)
        else $error("counter left its maximum without a transfer");
    a_restart_zero: assert property (
        latch |=> run_q == '0)
        else $error("running count did not restart at transfer");
    a_held_stable: assert property (
        !latch |=> $stable(held_q))
        else $error("held count changed between transfers");
endmodule

// ===== t1_receive_error_counters.sv
// Purpose: receive line, path and out-of-sync error counters for T1
// Assumes: event inputs are one-cycle pulses synchronous to mclk
// Notes: counts are transferred to host registers once per second
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/10ps
module t1_receive_error_counters #(
    parameter int unsigned SECOND_CYCLES = t1_err_pkg::SECOND_CYCLES,
    parameter int unsigned LCV_W = t1_err_pkg::LCV_WIDTH,
    parameter int unsigned PATH_W = t1_err_pkg::PATH_WIDTH,
    parameter int unsigned OOS_W = t1_err_pkg::OOS_WIDTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [t1_err_pkg::ADR_WIDTH-1:0] wb_adr_i,
    input wire logic [t1_err_pkg::SEL_WIDTH-1:0] wb_sel_i,
    input wire logic [t1_err_pkg::DAT_WIDTH-1:0] wb_dat_i,
    output logic [t1_err_pkg::DAT_WIDTH-1:0] wb_dat_o,
    output logic wb_ack_o,
    // line decoder events
    input wire logic bpv_evt,
    input wire logic codeword_viol,
    input wire logic zeros8_evt,
    input wire logic zeros16_evt,
    // framer events
    input wire logic rx_sync_lost,
    input wire logic crc6_err_evt,
    input wire logic ft_err_evt,
    input wire logic fs_err_evt,
    input wire logic fps_err_evt,
    input wire logic rx_multiframe_evt,
    // interrupt
    output logic irq
);
    import t1_err_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [CTRL_WIDTH-1:0] ctrl_reg;
    logic [STAT_WIDTH-1:0] status_reg;
    logic [STAT_WIDTH-1:0] status_next;
    logic [STAT_WIDTH-1:0] mask_reg;
    logic [31:0] sec_cnt_reg;
    logic ack_reg;
    logic [DAT_WIDTH-1:0] dat_reg;
    logic second_tick;
    logic bus_req;
    logic [7:0] idx;
    logic [7:0] rd_byte;

    logic excess_zero_count_en;
    logic rx_zero_substitution_mode;
    logic rx_framing_select;
    logic count_fs_errors_en;
    logic oos_count_select;

    logic [1:0] lcv_inc;
    logic [1:0] path_inc;
    logic [1:0] oos_inc;
    logic lcv_bpv_cnt;
    logic lcv_zero_cnt;

    logic [LCV_W-1:0] lcv_run;
    logic [LCV_W-1:0] line_violation_counter;
    logic [PATH_W-1:0] path_run;
    logic [PATH_W-1:0] path_error_counter;
    logic [OOS_W-1:0] oos_run;
    logic [OOS_W-1:0] out_of_sync_counter;
    logic lcv_full;
    logic path_full;
    logic oos_full;

    assign excess_zero_count_en = ctrl_reg[CTRL_EXCESS_ZERO];
    assign rx_zero_substitution_mode = ctrl_reg[CTRL_ZERO_SUB];
    assign rx_framing_select = ctrl_reg[CTRL_FRAMING_ESF];
    assign count_fs_errors_en = ctrl_reg[CTRL_COUNT_FS];
    assign oos_count_select = ctrl_reg[CTRL_OOS_SEL];

    ////////////////////////////////////////////////////////////////////////
    // one-second timer

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sec_cnt_reg <= 32'h00000000;
        end else if (second_tick) begin
            sec_cnt_reg <= 32'h00000000;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h00000001;
        end
    end

    assign second_tick = (sec_cnt_reg == 32'(SECOND_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////
    // event selection

    // substitution code words carry violations that are not errors
    assign lcv_bpv_cnt = bpv_evt
        && !(rx_zero_substitution_mode && codeword_viol);
    assign lcv_zero_cnt = excess_zero_count_en
        && (rx_zero_substitution_mode ? zeros8_evt
                                      : zeros16_evt);
    // no sync qualifier here: keeps counting while out of sync
    assign lcv_inc = {1'b0, lcv_bpv_cnt} + {1'b0, lcv_zero_cnt};

    always_comb begin
        path_inc = 2'h0;
        if (rx_sync_lost) begin
            path_inc = 2'h0;
        end else if (rx_framing_select) begin
            path_inc = {1'b0, crc6_err_evt};
        end else begin
            path_inc = {1'b0, ft_err_evt}
                + {1'b0, count_fs_errors_en && fs_err_evt};
        end
    end

    always_comb begin
        oos_inc = 2'h0;
        if (oos_count_select) begin
            oos_inc = {1'b0, rx_multiframe_evt && rx_sync_lost};
        end else if (!rx_sync_lost) begin
            oos_inc = {1'b0, rx_framing_select ? fps_err_evt
                                               : ft_err_evt};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counters

    sat_err_counter #(.W(LCV_W)) u_lcv (
        .mclk(mclk),
        .resetn(resetn),
        .inc(lcv_inc),
        .latch(second_tick),
        .run_q(lcv_run),
        .held_q(line_violation_counter),
        .full(lcv_full)
    );

    sat_err_counter #(.W(PATH_W)) u_path (
        .mclk(mclk),
        .resetn(resetn),
        .inc(path_inc),
        .latch(second_tick),
        .run_q(path_run),
        .held_q(path_error_counter),
        .full(path_full)
    );

    sat_err_counter #(.W(OOS_W)) u_oos (
        .mclk(mclk),
        .resetn(resetn),
        .inc(oos_inc),
        .latch(second_tick),
        .run_q(oos_run),
        .held_q(out_of_sync_counter),
        .full(oos_full)
    );

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign idx = wb_adr_i[9:2];

    always_comb begin
        case (idx)
            IDX_LCV_HI: rd_byte = line_violation_counter[15:8];
            IDX_LCV_LO: rd_byte = line_violation_counter[7:0];
            IDX_HIGH_NIBBLES: rd_byte = {out_of_sync_counter[11:8],
                path_error_counter[11:8]};
            IDX_PATH_LO: rd_byte = path_error_counter[7:0];
            IDX_OOS_LO: rd_byte = out_of_sync_counter[7:0];
            IDX_CTRL: rd_byte = {3'h0, ctrl_reg};
            IDX_STATUS: rd_byte = {6'h00, status_reg};
            IDX_MASK: rd_byte = {6'h00, mask_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    // one-cycle answer, dropped the cycle after it is given
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            dat_reg <= 32'h00000000;
        end else if (bus_req && !wb_we_i) begin
            dat_reg <= {24'h000000, rd_byte};
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    ////////////////////////////////////////////////////////////////////////
    // control and mask registers

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (bus_req && wb_we_i && wb_sel_i[0]
                     && idx == IDX_CTRL) begin
            ctrl_reg <= wb_dat_i[CTRL_WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mask_reg <= MASK_RESET;
        end else if (bus_req && wb_we_i && wb_sel_i[0]
                     && idx == IDX_MASK) begin
            mask_reg <= wb_dat_i[STAT_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status, write one to clear, set wins

    always_comb begin
        status_next = status_reg;
        if (bus_req && wb_we_i && wb_sel_i[0] && idx == IDX_STATUS) begin
            status_next = status_reg & ~wb_dat_i[STAT_WIDTH-1:0];
        end
        if (second_tick) begin
            status_next[STAT_SECOND] = 1'b1;
        end
        if (second_tick && (lcv_full || path_full || oos_full)) begin
            status_next[STAT_SATURATED] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            status_reg <= STAT_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    assign irq = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_read_req(logic [7:0] i);
        wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg && idx == i;
    endsequence

    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_second_transfer: assert property (
        second_tick |=> 17'(line_violation_counter)
            == 17'($past(lcv_run)) + 17'($past(lcv_inc))
            || line_violation_counter == '1 && $past(lcv_run) >= 16'hFFFE)
        else $error("line count not transferred at second boundary");

    a_lcv_hi_read: assert property (
        s_read_req(IDX_LCV_HI) |=> s_answer)
        else $error("read of line count high byte not answered");

    a_lcv_hi_data: assert property (
        s_read_req(IDX_LCV_HI)
            |=> wb_dat_o[7:0] == $past(line_violation_counter[15:8]))
        else $error("line count high byte misplaced");

    a_lcv_sixteen: assert property (
        excess_zero_count_en && !rx_zero_substitution_mode
            && zeros16_evt && !bpv_evt && !second_tick && !lcv_full
            |=> lcv_run == $past(lcv_run) + 16'h0001)
        else $error("run of sixteen zeros not counted");

    a_lcv_eight: assert property (
        excess_zero_count_en && rx_zero_substitution_mode
            && zeros8_evt && !bpv_evt && !second_tick && !lcv_full
            |=> lcv_run == $past(lcv_run) + 16'h0001)
        else $error("run of eight zeros not counted");

    a_codeword_skip: assert property (
        rx_zero_substitution_mode && bpv_evt && codeword_viol
            && !zeros8_evt && !second_tick |=> $stable(lcv_run))
        else $error("substitution code word counted as violation");

    a_lcv_in_loss: assert property (
        rx_sync_lost && bpv_evt && !codeword_viol && !second_tick
            && !lcv_full |=> lcv_run > $past(lcv_run))
        else $error("line count stopped during sync loss");

    a_path_mode: assert property (
        !rx_sync_lost && !second_tick && !path_full
            && rx_framing_select && crc6_err_evt
            |=> path_run == $past(path_run) + 12'h001)
        else $error("crc error not counted in esf framing");

    a_path_loss: assert property (
        rx_sync_lost && !second_tick |=> $stable(path_run))
        else $error("path count moved during sync loss");

    a_nibble_map: assert property (
        s_read_req(IDX_HIGH_NIBBLES) |=> wb_dat_o[7:0]
            == $past({out_of_sync_counter[11:8],
                      path_error_counter[11:8]}))
        else $error("shared nibble register layout wrong");

    a_oos_mode: assert property (
        oos_count_select && rx_sync_lost && rx_multiframe_evt
            && !second_tick && !oos_full
            |=> oos_run == $past(oos_run) + 12'h001)
        else $error("out of sync multiframe not counted");

    a_fbit_loss: assert property (
        !oos_count_select && rx_sync_lost && !second_tick
            |=> $stable(oos_run))
        else $error("framing bit count moved during sync loss");

    a_irq_level: assert property (
        status_reg[STAT_SECOND] && mask_reg[STAT_SECOND] |-> irq)
        else $error("unmasked status did not raise interrupt");

    a_tick_sets_flag: assert property (
        second_tick |=> status_reg[STAT_SECOND])
        else $error("second flag not set at transfer");

    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("bus answer held longer than one cycle");

endmodule

// ===== host_bus_model.sv
// Purpose: host side bus master that reads and writes the counter block
// Assumes: classic Wishbone, one request at a time, lane 0 data only
// Notes: waits for ack without limit; the bench watchdog ends a hang
`timescale 1ns/10ps
module host_bus_model (
    // clock
    input wire logic mclk,
    // wishbone master
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [9:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);

    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 10'h000;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one classic cycle; request held until the edge that sees ack
    // the bench reads counts right after each second event except the first, which t_irq only waits for
    task automatic xfer(input logic we, input logic [7:0] idx,
                        input logic [7:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= {idx, 2'h0};
        wb_sel_o <= 4'h1;
        wb_dat_o <= {24'h0, wd};
        // ack and read data are taken at the rising edge that sees ack
        @(posedge mclk);
        while (wb_ack_i !== 1'b1) begin
            @(posedge mclk);
        end
        rd = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
    endtask

endmodule

// ===== t1_receive_error_counters_tb_top.sv
// Purpose: self-checking bench for the receive error counters
// Assumes: short second of SEC cycles, event pulses one cycle apart except in t_sat and t_split, which hold events high
// Notes: each count window lies between two one-second interrupts
`timescale 1ns/10ps
module t1_receive_error_counters_tb_top;
    import t1_err_pkg::*;
    localparam int unsigned SEC = 5000;
    logic mclk;
    logic resetn;
    logic wb_cyc, wb_stb, wb_we, wb_ack, irq, sync_lost;
    logic [9:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat;
    logic [8:0] evt;
    int fail_count, tests_run, cycles;

    t1_receive_error_counters #(
        .SECOND_CYCLES(SEC)
    ) u_t1_receive_error_counters (
        .mclk(mclk), .resetn(resetn),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .bpv_evt(evt[0]), .codeword_viol(evt[1]), .zeros8_evt(evt[2]),
        .zeros16_evt(evt[3]), .rx_sync_lost(sync_lost),
        .crc6_err_evt(evt[4]), .ft_err_evt(evt[5]), .fs_err_evt(evt[6]),
        .fps_err_evt(evt[7]), .rx_multiframe_evt(evt[8]), .irq(irq)
    );

    host_bus_model u_host_bus_model (
        .mclk(mclk), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
        .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat),
        .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        u_host_bus_model.xfer(1'b1, idx, d, unused);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        u_host_bus_model.xfer(1'b0, idx, 8'h00, d);
    endtask

    task automatic send(input logic [8:0] v, input int n);
        repeat (n) begin
            @(posedge mclk);
            evt <= v;
            @(posedge mclk);
            evt <= 9'h000;
        end
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < SEC + 100) begin
            @(negedge mclk);
            n++;
        end
        chk({31'h0, irq}, 32'h1, "second tick");
    endtask

    task automatic tick();
        wait_irq();
        wr(IDX_STATUS, 8'h01);
    endtask

    task automatic counts(output logic [31:0] l, p, o);
        logic [31:0] a, b, c, d, e;
        rd(IDX_LCV_HI, a);
        rd(IDX_LCV_LO, b);
        rd(IDX_HIGH_NIBBLES, c);
        rd(IDX_PATH_LO, d);
        rd(IDX_OOS_LO, e);
        l = (a << 8) | b;
        p = ((c & 32'h0F) << 8) | d;
        o = ((c >> 4) << 8) | e;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_regs();
        logic [31:0] d;
        logic [7:0] idxs [9];
        idxs = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h30, 8'h31, 8'h32,
                 8'h3F};
        wr(IDX_LCV_HI, 8'hFF);
        wr(8'h3F, 8'hFF);
        for (int i = 0; i < 9; i++) begin
            rd(idxs[i], d);
            chk(d, 32'h0, "reset or ignored write");
        end
        wr(IDX_MASK, 8'h03);
        rd(IDX_MASK, d);
        chk(d, 32'h3, "mask readback");
        wr(IDX_CTRL, 8'h1F);
        rd(IDX_CTRL, d);
        chk(d, 32'h1F, "ctrl readback");
        chk({31'h0, irq}, 32'h0, "irq idle");
        $display("test regs done");
    endtask

    task automatic t_irq();
        logic [31:0] d;
        wait_irq();
        wr(IDX_MASK, 8'h02);
        chk({31'h0, irq}, 32'h0, "irq masked");
        rd(IDX_STATUS, d);
        chk(d, 32'h1, "status sticky");
        wr(IDX_MASK, 8'h01);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(IDX_STATUS, 8'h01);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("test irq done");
    endtask

    // same event mix every second, expectations follow the mode
    task automatic t_mode(input logic [4:0] c, input logic sl);
        logic [31:0] l, p, o, el, ep, eo;
        wr(IDX_CTRL, {3'h0, c});
        sync_lost <= sl;
        send(9'h001, 3);
        send(9'h003, 1);
        send(9'h004, 2);
        send(9'h008, 3);
        send(9'h010, 2);
        send(9'h020, 3);
        send(9'h040, 1);
        send(9'h080, 4);
        send(9'h100, 5);
        @(posedge mclk);
        sync_lost <= 1'b0;
        tick();
        counts(l, p, o);
        el = (c[1] ? 3 : 4) + (c[0] ? (c[1] ? 2 : 3) : 0);
        ep = sl ? 0 : c[2] ? 2 : 3 + c[3];
        eo = c[4] ? (sl ? 5 : 0) : sl ? 0 : c[2] ? 4 : 3;
        chk(l, el, "line count");
        chk(p, ep, "path count");
        chk(o, eo, "oos count");
        $display("test mode %h sync_lost %b done", c, sl);
    endtask

    task automatic t_sat();
        logic [31:0] l, p, o, s;
        wr(IDX_CTRL, 8'h00);
        @(posedge mclk);
        evt <= 9'h021;
        repeat (4100) @(posedge mclk);
        evt <= 9'h000;
        tick();
        counts(l, p, o);
        rd(IDX_STATUS, s);
        chk(l, 32'h1004, "line count long run");
        chk(p, 32'hFFF, "path saturated");
        chk(o, 32'hFFF, "oos saturated");
        chk(s, 32'h2, "saturation flag");
        $display("test saturation done");
    endtask

    // violations held high for one second, straddling a transfer edge
    task automatic t_split();
        logic [31:0] l1, l2, p, o;
        wr(IDX_CTRL, 8'h00);
        @(posedge mclk);
        evt <= 9'h001;
        fork
            begin
                repeat (SEC) @(posedge mclk);
                evt <= 9'h000;
            end
            begin
                tick();
                counts(l1, p, o);
            end
        join
        tick();
        counts(l2, p, o);
        chk(l1 + l2, SEC, "events split over transfer");
        chk({31'h0, l2 != 0}, 32'h1, "events after transfer");
        $display("test split done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock, watchdog and main sequence
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles > 65000) begin
            fail_count++;
            $display("[ERR] %0t run took too long", $time);
            end_of_test();
        end
    end

    initial begin
        resetn = 1'b0;
        evt = 9'h000;
        sync_lost = 1'b0;
        fail_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        t_irq();
        t_mode(5'h00, 1'b0);
        t_mode(5'h01, 1'b1);
        t_mode(5'h02, 1'b0);
        t_mode(5'h0B, 1'b0);
        t_mode(5'h0C, 1'b0);
        t_mode(5'h14, 1'b1);
        t_mode(5'h10, 1'b0);
        t_sat();
        t_split();
        end_of_test();
    end

endmodule
